// *** hw/dxb_pins_top.sv ***
// External parallel bus, interrupt and reset pin logic of a fixed-point DSP.
// Assumes pins arrive asynchronously and a core issues one request at a time.
// How it works
// - Low sixteen address lines serve all spaces.
// - Upper seven lines only extend program space.
// - All address lines float in hold.
// - Host select makes low lines host inputs.
// - Address holder keeps last level while floating.
// - Data bus moves words, host transfers too.
// - Data floats unless writing, reset, hold.
// - Float request floats address, data, acknowledge.
// - Data holder keeps level; software enables.
// - Acknowledge with vector on low lines, except in host mode.
// - Four lines masked, prioritised by mode.
// - Pending lines visible and clearable in flags.
// - Nonmaskable line ignores all masks.
// - Nonmaskable trap loads its own vector.
// - Reset stops execution, counter at FF80.
// - After reset, execution starts at FF80.
// - Grant given only after lines float.
`timescale 1ns/100ps
module dxb_pins_top
    import dxb_pkg::*;
(
    input  wire logic           pclk,           // Clock, 100 MHz.
    input  wire logic           presetn,        // Asynchronous reset, active low.
    input  wire logic           psel,           // APB select.
    input  wire logic           penable,        // APB enable.
    input  wire logic           pwrite,         // APB direction.
    input  wire logic [PAW-1:0] paddr,          // APB byte address.
    input  wire logic [31:0]    pwdata,         // APB write data.
    output logic      [31:0]    prdata,         // APB read data.
    output logic                pready,         // APB ready.
    output logic                pslverr,        // APB error, unmapped address.
    input  wire logic           core_req,       // Core bus request.
    input  wire logic [1:0]     core_space,     // Program, data or I/O space.
    input  wire logic [AW-1:0]  core_addr,      // Core address.
    input  wire logic           core_we,        // Core write.
    input  wire logic [DW-1:0]  core_wdata,     // Core write data.
    input  wire logic           core_step,      // Core advances the counter.
    output logic      [DW-1:0]  core_rdata,     // Read data.
    output logic                core_done,      // Access finished pulse.
    output logic      [LAW-1:0] core_pc,        // Program counter.
    output logic                core_run,       // Execution allowed.
    input  wire logic [LAW-1:0] addr_rx,        // Low address pins sensed.
    output logic      [AW-1:0]  addr_tx,        // Address pins driven level.
    output logic                addr_oe_lo,     // Drive enable, low lines.
    output logic                addr_oe_hi,     // Drive enable, upper lines.
    input  wire logic [DW-1:0]  data_rx,        // Data pins sensed.
    output logic      [DW-1:0]  data_tx,        // Data pins driven or kept level.
    output logic                data_oe,        // Data strong drive enable.
    output logic                data_keep,      // Data holder active.
    input  wire logic           chip_reset_in_n,  // Reset pin, active low.
    input  wire logic           bus_hold_req_n,   // Bus release request, active low.
    input  wire logic           float_req_n,      // Output float request, active low.
    input  wire logic           host_port_16bit_select, // Host port mode.
    output logic      [LAW-1:0] host_addr,      // Host address to internal memory.
    output logic      [DW-1:0]  host_data,      // Host data word sensed.
    output logic                bus_release_grant_n,  // Grant, active low.
    output logic                grant_oe,       // Grant pin drive enable.
    input  wire logic [NIRQ-1:0] external_irq_lines_n, // Maskable lines, low.
    input  wire logic           nmi_n,          // Nonmaskable line, low.
    output logic                interrupt_ack_out_n, // Acknowledge, low.
    output logic                interrupt_ack_out_oe,        // Acknowledge drive enable.
    output logic                irq             // Level interrupt to host CPU.
);

    // Pick one pending line; mode 0 favours line 0, mode 1 favours line 3.
    function automatic logic [1:0] dxb_pick(input logic [NIRQ-1:0] av, input logic md);
        logic [1:0] r;
        r = 2'h0;
        for (int k = NIRQ - 1; k >= 0; k--) begin
            if (av[md ? NIRQ - 1 - k : k]) begin
                r = 2'(md ? NIRQ - 1 - k : k);
            end
        end
        return r;
    endfunction : dxb_pick

    logic [PV_W-1:0] pin_m_q, pin_s_q;
    logic [NIRQ-1:0] int_prev_q, flag_q, flag_d, mask_q;
    logic            nmi_prev_q, nmi_pend_q, gmask_q, gmask_d, mode_q, dhold_q;
    logic [NEVT-1:0] evt_q, evt_d, een_q, evt_set;
    dxb_state_e      st_q, st_d;
    logic [CW-1:0]   cnt_q;
    logic [1:0]      sp_q;
    logic [AW-1:0]   ad_q;
    logic            we_q, rst_prev_q, pready_q, grant_d;
    logic [DW-1:0]   wd_q;
    logic [31:0]     rd_mux;

    // Pin view after the synchroniser; only the second flop is read.
    wire        in_rst   = !pin_s_q[PV_RST];
    wire        hold_rq  = !pin_s_q[PV_HOLD];
    wire        off_ok   = pin_s_q[PV_OFF];
    wire        host_access_port      = pin_s_q[PV_HPI];
    wire [NIRQ-1:0] int_l = pin_s_q[PV_INT +: NIRQ];
    wire        nmi_l    = pin_s_q[PV_NMI];
    wire [NIRQ-1:0] set_v = int_prev_q & ~int_l;
    wire        nmi_fall = nmi_prev_q & !nmi_l;
    wire [NIRQ-1:0] avail = flag_q & mask_q;
    // A hold request stops interrupt entry, so no vector is taken without its acknowledge.
    wire        idle_ok  = (st_q == ST_IDLE) && !in_rst && !hold_rq;
    wire        take_nmi = idle_ok && nmi_pend_q;
    wire        take_irq = idle_ok && !nmi_pend_q && !gmask_q && |avail;
    wire [1:0]  pick     = dxb_pick(avail, mode_q);
    wire [LAW-1:0] vec   = take_nmi ? NMI_VEC
                           : INT_VEC_BASE + LAW'({14'h0000, pick} << VEC_SHIFT);

    // APB decode; the write lands on the edge where pready is seen high.
    wire acc     = psel && penable;
    wire fire    = acc && pready_q;
    wire wr      = fire && pwrite;
    wire hit_ctl = paddr == REG_CTRL;
    wire hit_msk = paddr == REG_MASK;
    wire hit_flg = paddr == REG_FLAG;
    wire hit_sta = paddr == REG_STAT;
    wire hit_evt = paddr == REG_EVT;
    wire hit_ecl = paddr == REG_ECLR;
    wire hit_een = paddr == REG_EEN;
    wire hit_any = hit_ctl | hit_msk | hit_flg | hit_sta | hit_evt | hit_ecl | hit_een;

    // Flag clear by software yields to a new edge in the same cycle.
    wire [NIRQ-1:0] take_clr = take_irq ? NIRQ'(1) << pick : '0;
    wire [NIRQ-1:0] sw_clr   = (wr && hit_flg) ? pwdata[NIRQ-1:0] : '0;
    assign flag_d  = set_v | (flag_q & ~sw_clr & ~take_clr);
    assign gmask_d = (take_irq || take_nmi) ? 1'b1
                     : (wr && hit_ctl) ? pwdata[CTRL_GMASK] : gmask_q;
    assign evt_set[EVT_IRQ]  = take_irq;
    assign evt_set[EVT_NMI]  = take_nmi;
    assign evt_set[EVT_HOLD] = (st_q == ST_HOLD) && bus_release_grant_n && grant_d;
    assign evt_set[EVT_RUN]  = rst_prev_q && !in_rst;
    assign evt_d = evt_set | (evt_q & ~((wr && hit_ecl) ? pwdata[NEVT-1:0] : '0));

    // Read mux; write-only clear register reads as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctl) begin
            rd_mux[CTRL_GMASK:0] = {gmask_q, mode_q, dhold_q};
        end
        if (hit_msk) begin
            rd_mux[NIRQ-1:0] = mask_q;
        end
        if (hit_flg) begin
            rd_mux[NIRQ-1:0] = flag_q;
        end
        if (hit_sta) begin
            rd_mux = {12'h000, !off_ok, in_rst, host_access_port, st_q == ST_HOLD, core_pc};
        end
        if (hit_evt) begin
            rd_mux[NEVT-1:0] = evt_q;
        end
        if (hit_een) begin
            rd_mux[NEVT-1:0] = een_q;
        end
    end

    // Bus sequencer: interrupt entry beats a bus request, hold waits for idle.
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (hold_rq) begin
                    st_d = ST_HOLD;
                end else if (take_nmi || take_irq) begin
                    st_d = ST_INTERRUPT_ACK_OUT;
                end else if (core_req && !in_rst && !core_done) begin  // No retake of a finished request.
                    st_d = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (cnt_q == ACC_LAST) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_q == SYNC_LAST) begin
                    st_d = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (!hold_rq) begin
                    st_d = ST_IDLE;
                end
            end
            ST_INTERRUPT_ACK_OUT: begin
                if (cnt_q == INTERRUPT_ACK_OUT_LAST) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Pad enables. Reset and hold force the data bus off.
    wire fl      = (st_d == ST_HOLD) || !off_ok;
    wire aoe_hi  = !fl;
    wire aoe_lo  = !fl && !host_access_port;
    wire ld_req  = (st_q == ST_IDLE) && (st_d == ST_DRIVE);
    // On the take edge the latch still holds the previous request, so use the live one.
    wire doe     = (st_d == ST_DRIVE) && (ld_req ? core_we : we_q)
                   && !in_rst && !hold_rq && !fl;
    assign grant_d = (st_q == ST_HOLD) && !addr_oe_hi && !addr_oe_lo && !data_oe;
    // Upper lines carry bits only for program space; low lines serve all spaces.
    wire [AW-1:0] req_a = (core_space == SP_PROG) ? core_addr
                          : {{(AW-LAW){1'b0}}, core_addr[LAW-1:0]};

    // Two-flop synchroniser for every pin that comes from outside.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_m_q <= PIN_RST;
            pin_s_q <= PIN_RST;
        end else begin
            pin_m_q <= {data_rx, addr_rx, external_irq_lines_n, nmi_n, chip_reset_in_n,
                        host_port_16bit_select, float_req_n, bus_hold_req_n};
            pin_s_q <= pin_m_q;
        end
    end

    // Interrupt capture on falling edges of the synchronised lines.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_prev_q <= '1;
            nmi_prev_q <= 1'b1;
            nmi_pend_q <= 1'b0;
            flag_q     <= '0;
            gmask_q    <= 1'b0;
        end else begin
            int_prev_q <= int_l;
            nmi_prev_q <= nmi_l;
            nmi_pend_q <= nmi_fall || (nmi_pend_q && !take_nmi);
            flag_q     <= flag_d;
            gmask_q    <= gmask_d;
        end
    end

    // Software registers and sticky events.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mode_q, dhold_q} <= CTRL_RST[CTRL_MODE:0];
            mask_q <= '0;
            een_q  <= '0;
            evt_q  <= '0;
            irq    <= 1'b0;
        end else begin
            if (wr && hit_ctl) begin
                {mode_q, dhold_q} <= pwdata[CTRL_MODE:0];
            end
            if (wr && hit_msk) begin
                mask_q <= pwdata[NIRQ-1:0];
            end
            if (wr && hit_een) begin
                een_q <= pwdata[NEVT-1:0];
            end
            evt_q <= evt_d;
            irq   <= |(evt_q & een_q);
        end
    end

    // APB answer: pready one cycle into the access phase, data with it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pready   <= 1'b0;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
        end else begin
            pready_q <= acc && !pready_q;
            pready   <= acc && !pready_q;
            prdata   <= (acc && !pready_q && !pwrite) ? rd_mux : 32'h0000_0000;
            pslverr  <= acc && !pready_q && !hit_any;
        end
    end

    // Sequencer state, request latch and program counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= ST_IDLE;
            cnt_q      <= '0;
            sp_q       <= SP_PROG;
            ad_q       <= '0;
            we_q       <= 1'b0;
            wd_q       <= '0;
            core_pc    <= RESET_VEC;
            core_run   <= 1'b0;
            core_done  <= 1'b0;
            core_rdata <= '0;
            rst_prev_q <= 1'b0;  // Matches the idle pin view, so no false release event.
        end else begin
            st_q       <= in_rst ? ST_IDLE : st_d;
            cnt_q      <= (st_d != st_q) ? '0 : cnt_q + 4'h1;
            rst_prev_q <= in_rst;
            core_run   <= !in_rst;
            core_done  <= (st_q == ST_WAIT) && (st_d == ST_IDLE);
            if (ld_req) begin
                sp_q <= core_space;
                ad_q <= req_a;
                we_q <= core_we;
                wd_q <= core_wdata;
            end
            if ((st_q == ST_WAIT) && (st_d == ST_IDLE) && !we_q) begin
                core_rdata <= pin_s_q[PV_D +: DW];
            end
            if (in_rst) begin
                core_pc <= RESET_VEC;
            end else if (take_nmi || take_irq) begin
                core_pc <= vec;
            end else if (core_step && st_q == ST_IDLE) begin
                core_pc <= core_pc + 16'h0001;
            end
        end
    end

    // Pads. Address values change only when a request or vector is loaded; data follows the
    // sensed pins while not driven, so the registered level is the holder level once the enable drops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_tx    <= '0;
            addr_oe_lo <= 1'b0;
            addr_oe_hi <= 1'b0;
            data_tx    <= '0;
            data_oe    <= 1'b0;
            data_keep  <= 1'b0;
            host_addr  <= '0;
            host_data  <= '0;
            bus_release_grant_n <= 1'b1;
            grant_oe   <= 1'b0;
            interrupt_ack_out_n <= 1'b1;
            interrupt_ack_out_oe    <= 1'b0;
        end else begin
            if (ld_req && !fl) begin
                addr_tx <= req_a;
            end else if ((take_nmi || take_irq) && !fl) begin
                addr_tx <= {ad_q[AW-1:LAW], vec};
            end
            addr_oe_lo <= aoe_lo;
            addr_oe_hi <= aoe_hi;
            if (doe) begin
                data_tx <= ld_req ? core_wdata : wd_q;
            end else if (!data_oe) begin
                data_tx <= pin_s_q[PV_D +: DW];
            end
            data_oe    <= doe;
            data_keep  <= dhold_q && !doe;
            if (host_access_port) begin
                host_addr <= pin_s_q[PV_A +: LAW];
                host_data <= pin_s_q[PV_D +: DW];
            end
            bus_release_grant_n <= !grant_d;
            grant_oe   <= off_ok;
            interrupt_ack_out_n <= !(st_d == ST_INTERRUPT_ACK_OUT);
            interrupt_ack_out_oe    <= off_ok;
        end
    end

    // Reset keeps the counter at the reset vector and execution stopped.
    AST_RESET_PC: assert property (@(posedge pclk) disable iff (!presetn)
        in_rst |=> (core_pc == RESET_VEC) && !core_run)
        else $error("Counter not at reset vector during reset.");

    AST_RUN_START: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(in_rst) |-> core_pc == RESET_VEC ##1 core_run)
        else $error("Execution did not start at the reset vector.");

    AST_DATA_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
        (in_rst || hold_rq) |=> !data_oe)
        else $error("Data bus driven during reset or hold request.");

    AST_HOLD_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_HOLD) |-> !addr_oe_hi && !addr_oe_lo && !data_oe)
        else $error("Address bus driven in hold.");

    AST_HPI_INPUT: assert property (@(posedge pclk) disable iff (!presetn)
        host_access_port |=> !addr_oe_lo)
        else $error("Low address lines driven in host port mode.");

    AST_FLOAT_REQ: assert property (@(posedge pclk) disable iff (!presetn)
        !off_ok |=> !addr_oe_hi && !data_oe && !interrupt_ack_out_oe)
        else $error("Outputs driven while float requested.");

    AST_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(bus_release_grant_n) |-> $past(!addr_oe_hi && !data_oe) && st_q == ST_HOLD)
        else $error("Grant given before lines floated.");

    // Interrupt entry: one-cycle acknowledge with the vector on the low lines.
    sequence s_ack;
        !interrupt_ack_out_n && addr_tx[LAW-1:0] == core_pc ##1 interrupt_ack_out_n;
    endsequence
    AST_INTERRUPT_ACK_OUT_VEC: assert property (@(posedge pclk) disable iff (!presetn)
        (take_irq || take_nmi) && !hold_rq && off_ok && !host_access_port |=> s_ack)
        else $error("Acknowledge without the vector on the address lines.");

    AST_NMI_TRAP: assert property (@(posedge pclk) disable iff (!presetn)
        take_nmi && !hold_rq |=> st_q == ST_INTERRUPT_ACK_OUT && core_pc == NMI_VEC)
        else $error("Nonmaskable interrupt not trapped to its vector.");

    AST_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
        take_irq |-> !gmask_q && |(flag_q & mask_q) ##1 gmask_q)
        else $error("Masked interrupt taken or global mask not set.");

    AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        |set_v |=> |(flag_q & $past(set_v)))
        else $error("Interrupt edge lost from the flag register.");

    AST_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ST_DRIVE) && (sp_q != SP_PROG) |-> addr_tx[AW-1:LAW] == '0)
        else $error("Upper address lines used outside program space.");

endmodule : dxb_pins_top

// *** hw/dxb_pkg.sv ***
// Constants, register map and state type for the external bus and interrupt pin block.
// Assumes one 100 MHz clock and an APB slave with a byte address of PAW bits.
package dxb_pkg;
    localparam int AW      = 23;              // Full address bus width.
    localparam int LAW     = 16;              // Shared low address lines.
    localparam int DW      = 16;              // Data bus width.
    localparam int NIRQ    = 4;               // External maskable interrupt lines.
    localparam int PAW     = 8;               // APB address width.
    localparam int CW      = 4;               // Sequence counter width.
    localparam int CLK_NS  = 10;              // Clock period in ns.
    localparam int ACC_NS  = 20;              // Least time an address is driven, ns.
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [CW-1:0] ACC_LAST  = CW'(ACC_CYC - 1);
    localparam logic [CW-1:0] SYNC_LAST = 4'h2;  // Read data crosses two flops.
    localparam logic [CW-1:0] INTERRUPT_ACK_OUT_LAST = 4'h0;  // Acknowledge lasts one cycle.
    // Program counter values and vector placement.
    localparam logic [LAW-1:0] RESET_VEC    = 16'hFF80;
    localparam logic [LAW-1:0] NMI_VEC      = 16'hFF84;
    localparam logic [LAW-1:0] INT_VEC_BASE = 16'hFFC0;
    localparam int             VEC_SHIFT    = 2;
    // Address space codes of a core request.
    localparam logic [1:0] SP_PROG = 2'h0;
    localparam logic [1:0] SP_DATA = 2'h1;
    localparam logic [1:0] SP_IO   = 2'h2;
    // Register byte offsets.
    localparam logic [PAW-1:0] REG_CTRL = 8'h00;
    localparam logic [PAW-1:0] REG_MASK = 8'h04;
    localparam logic [PAW-1:0] REG_FLAG = 8'h08;
    localparam logic [PAW-1:0] REG_STAT = 8'h0C;
    localparam logic [PAW-1:0] REG_EVT  = 8'h10;
    localparam logic [PAW-1:0] REG_ECLR = 8'h14;
    localparam logic [PAW-1:0] REG_EEN  = 8'h18;
    // Field positions.
    localparam int CTRL_DHOLD = 0;
    localparam int CTRL_MODE  = 1;
    localparam int CTRL_GMASK = 2;
    localparam int STAT_HOLD  = 16;
    localparam int STAT_HPI   = 17;
    localparam int STAT_RST   = 18;
    localparam int STAT_OFF   = 19;
    localparam int NEVT       = 4;
    localparam int EVT_IRQ    = 0;
    localparam int EVT_NMI    = 1;
    localparam int EVT_HOLD   = 2;
    localparam int EVT_RUN    = 3;
    localparam logic [2:0] CTRL_RST = 3'h1;   // Data holder on, mode 0, mask clear.
    // Layout of the synchronised pin vector.
    localparam int PV_HOLD = 0;
    localparam int PV_OFF  = 1;
    localparam int PV_HPI  = 2;
    localparam int PV_RST  = 3;
    localparam int PV_NMI  = 4;
    localparam int PV_INT  = 5;
    localparam int PV_A    = 9;
    localparam int PV_D    = 25;
    localparam int PV_W    = 41;
    localparam logic [PV_W-1:0] PIN_RST = 41'h000_0000_01FB;  // Lines idle.
    typedef enum logic [2:0] {ST_IDLE, ST_DRIVE, ST_WAIT, ST_HOLD, ST_INTERRUPT_ACK_OUT} dxb_state_e;
endpackage : dxb_pkg

// *** tb/dxb_ext_model.sv ***
// Far side of the pin block: external memory, address holder and a host on the low lines.
// Assumes the bench drives host_a and the interrupt and control pins itself.
`timescale 1ns/100ps
module dxb_ext_model
    import dxb_pkg::*;
(
    input  wire logic [AW-1:0]  addr_tx,    // Address level from the device.
    input  wire logic           addr_oe_lo, // Device drives low lines.
    input  wire logic [DW-1:0]  data_tx,    // Data level from the device.
    input  wire logic           data_oe,    // Device drives data.
    input  wire logic           host_sel,   // Host mode pin.
    input  wire logic [LAW-1:0] host_a,     // Address the host drives.
    output logic      [LAW-1:0] addr_rx,    // Resolved low address lines.
    output logic      [DW-1:0]  data_rx     // Resolved data lines.
);
    // The holder keeps the last level when nobody drives; the host drives in host mode.
    assign addr_rx = addr_oe_lo ? addr_tx[LAW-1:0] : (host_sel ? host_a : addr_tx[LAW-1:0]);
    // Memory answers every read with the inverse of the low address, never the last write.
    assign data_rx = data_oe ? data_tx : ~addr_tx[LAW-1:0];
endmodule : dxb_ext_model

// *** tb/dxb_pins_top_tb.sv ***
// Self-checking bench for the pin block: APB registers, core bus, hold, float, interrupts.
// Assumes the memory model above; pins change only just after a rising edge.
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module dxb_pins_top_tb;
    import dxb_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, core_req = 0;
    logic core_we = 0, core_done, core_run, addr_oe_lo, addr_oe_hi, data_oe, data_keep, irq;
    logic rst_n = 0, hold_n = 1, off_n = 1, hsel = 0, grant_n, grant_oe, nmi_n = 1, ack_n, interrupt_ack_out_oe;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [1:0] core_space = 0;
    logic [22:0] core_addr = 0, addr_tx;
    logic [15:0] core_wdata = 0, core_rdata, core_pc, addr_rx, data_tx, data_rx, host_addr, host_data;
    logic [15:0] host_a = 16'h3C5A, rd;
    logic [3:0] irq_n = 4'hF;
    int fail_count = 0, total_checks = 0;
    logic drv;
    always #5 pclk = ~pclk;
    dxb_pins_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_req(core_req), .core_space(core_space), .core_addr(core_addr),
        .core_we(core_we), .core_wdata(core_wdata), .core_step(1'b0), .core_rdata(core_rdata),
        .core_done(core_done), .core_pc(core_pc), .core_run(core_run), .addr_rx(addr_rx),
        .addr_tx(addr_tx), .addr_oe_lo(addr_oe_lo), .addr_oe_hi(addr_oe_hi), .data_rx(data_rx),
        .data_tx(data_tx), .data_oe(data_oe), .data_keep(data_keep), .chip_reset_in_n(rst_n),
        .bus_hold_req_n(hold_n), .float_req_n(off_n), .host_port_16bit_select(hsel),
        .host_addr(host_addr), .host_data(host_data), .bus_release_grant_n(grant_n),
        .grant_oe(grant_oe), .external_irq_lines_n(irq_n), .nmi_n(nmi_n),
        .interrupt_ack_out_n(ack_n), .interrupt_ack_out_oe(interrupt_ack_out_oe), .irq(irq));
    dxb_ext_model EXT (.addr_tx(addr_tx), .addr_oe_lo(addr_oe_lo), .data_tx(data_tx),
        .data_oe(data_oe), .host_sel(hsel), .host_a(host_a), .addr_rx(addr_rx), .data_rx(data_rx));
    // APB master: request held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; drv = pslverr; psel <= 0; penable <= 0;
    endtask : apb
    // Core access; drv notes whether the write word was driven onto the data lines.
    task automatic core(input logic [1:0] sp, input logic [22:0] a, input logic w);
        @(posedge pclk); core_space <= sp; core_addr <= a; core_we <= w; core_req <= 1;
        drv = 0;
        do begin @(posedge pclk);
            if (data_oe === 1'b1 && data_tx === core_wdata) drv = 1;
        end while (core_done !== 1'b1);
        rd = core_rdata; core_req <= 0;
    endtask : core
    // Waits a bounded time for the acknowledge, then checks the vector on the low lines.
    task automatic ack_vec(input logic [15:0] v);
        for (int i = 0; i < 30 && ack_n !== 1'b0; i++) @(posedge pclk);
        `CHK("vector", v, addr_tx[15:0])
        irq_n <= 4'hF; nmi_n <= 1;
    endtask : ack_vec
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial begin #100000; fail_count++; finish_test; end
    initial begin
        repeat (3) @(posedge pclk); presetn <= 1; repeat (4) @(posedge pclk);
        `CHK("pc held", RESET_VEC, core_pc)
        `CHK("run held", 1'b0, core_run)
        `CHK("keep", 1'b1, data_keep)
        rst_n <= 1; repeat (5) @(posedge pclk);
        `CHK("pc start", RESET_VEC, core_pc)
        `CHK("run", 1'b1, core_run)
        $display("test reset done");
        core(SP_PROG, 23'h5A1234, 0); `CHK("prog addr", 23'h5A1234, addr_tx)
        `CHK("prog read", 16'hEDCB, rd)
        core_wdata <= 16'hBEEF; core(SP_DATA, 23'h7AF00D, 1); `CHK("wr drive", 1'b1, drv)
        `CHK("data addr", 23'h00F00D, addr_tx)
        @(posedge pclk); `CHK("data float", 1'b0, data_oe)
        $display("test core done");
        hold_n <= 0; for (int i = 0; i < 20 && grant_n !== 1'b0; i++) @(posedge pclk);
        `CHK("grant", 1'b0, grant_n)
        `CHK("hold oe", 3'h0, {addr_oe_lo, addr_oe_hi, data_oe})
        hsel <= 1; repeat (4) @(posedge pclk); `CHK("host addr", 16'h3C5A, host_addr)
        `CHK("host data", 16'h0FF2, host_data)
        hsel <= 0; hold_n <= 1; off_n <= 0; repeat (5) @(posedge pclk);
        `CHK("float oe", 5'h00, {addr_oe_lo, addr_oe_hi, data_oe, interrupt_ack_out_oe, grant_oe})
        off_n <= 1; repeat (5) @(posedge pclk); $display("test hold done");
        apb(1, REG_MASK, 32'h4); apb(1, REG_EEN, 32'h1); irq_n <= 4'hB;
        ack_vec(INT_VEC_BASE + 16'h0008); apb(0, REG_FLAG, 0); `CHK("flag", 32'h0, r)
        `CHK("irq pin", 1'b1, irq)
        apb(1, REG_ECLR, 32'hF); @(posedge pclk); @(posedge pclk); `CHK("irq clr", 1'b0, irq)
        nmi_n <= 0; ack_vec(NMI_VEC);
        apb(1, REG_CTRL, 32'h2); apb(1, REG_MASK, 32'hF); irq_n <= 4'h6;
        ack_vec(INT_VEC_BASE + 16'h000C); `CHK("keep off", 1'b0, data_keep)
        apb(0, 8'h40, 0); `CHK("unmapped", 1'b1, drv)
        $display("test irq done");
        finish_test;
    end
endmodule : dxb_pins_top_tb
